/* src/ued_consts.vh */
// Constants of the endpoint buffer and DMA block: register offsets,
// field positions, reset values and handshake codes.
// Assumes it is included by bare name into each design file.
`ifndef UED_CONSTS_VH
`define UED_CONSTS_VH

// ************
// Register offsets on the 5-bit register port.
// ************
`define UED_A_DEV_ADDR   5'h00
`define UED_A_EP_ENABLE  5'h01
`define UED_A_EP_DIR_IN  5'h02
`define UED_A_EP_ISO     5'h03
`define UED_A_DMA_CFG    5'h04
`define UED_A_BURST      5'h05
`define UED_A_COUNT      5'h06
`define UED_A_IRQ        5'h07
`define UED_A_HW_CFG     5'h08
`define UED_A_EP_STAT_HI 1'b1

// ************
// Field positions.
// ************
`define UED_DMA_EN_BIT   0
`define UED_DMA_IDX_LSB  4
`define UED_DMA_IDX_MSB  7
`define UED_SHARED_BIT   0

// ************
// Reset values.
// ************
`define UED_RST_DEV_ADDR 7'h00
`define UED_RST_EP_MASK  16'h0000
`define UED_RST_BURST    8'h10
`define UED_RST_COUNT    16'h0000
`define UED_RST_IDX      4'h1

// ************
// Handshake codes sent back to the serial engine.
// ************
`define UED_HS_ACK       2'h0
`define UED_HS_NAK       2'h1

// ************
// Endpoint range allowed to use DMA.
// ************
`define UED_DMA_EP_FIRST 4'h1
`define UED_DMA_EP_LAST  4'he

`endif

/* src/ued_pingpong.v */
// Ping-pong pair of packet buffers for one endpoint.
// Assumes one writer and one reader that never touch the same buffer:
// the writer fills only a free buffer, the reader drains only a full one.
`include "ued_consts.vh"

module ued_pingpong #(
    parameter DEPTH = 64,
    parameter PW    = 7
) (
    input  wire          clk_sys,
    input  wire          reset,
    input  wire          wr_en,
    input  wire [7:0]    wr_data,
    input  wire          wr_commit,
    input  wire          rd_en,
    input  wire          rd_release,
    input  wire          rd_rewind,
    output wire [1:0]    full,
    output wire          wr_free,
    output wire          wr_at_end,
    output wire          wr_any,
    output wire          rd_avail,
    output wire          rd_last,
    output reg  [7:0]    rd_data_q
);
    localparam [PW-1:0] LAST = DEPTH[PW-1:0] - 1'b1;
    localparam [PW-1:0] SIZE = DEPTH[PW-1:0];

    reg [7:0]    mem [0:2*DEPTH-1];
    reg [1:0]    full_q;
    reg [PW-1:0] len0_q;
    reg [PW-1:0] len1_q;
    reg          wr_sel_q;
    reg [PW-1:0] wr_ptr_q;
    reg          rd_sel_q;
    reg [PW-1:0] rd_ptr_q;
    reg          rd_sel_d;
    reg [PW-1:0] rd_ptr_d;

    wire          wr_ok  = wr_en && (wr_ptr_q != SIZE);
    wire [PW-1:0] wr_cnt = wr_ptr_q + {{(PW-1){1'b0}}, wr_ok};
    wire [PW-1:0] rd_len = rd_sel_q ? len1_q : len0_q;

    assign full      = full_q;
    assign wr_free   = ~full_q[wr_sel_q];
    assign wr_at_end = (wr_ptr_q == LAST);
    assign wr_any    = (wr_ptr_q != {PW{1'b0}});
    assign rd_avail  = full_q[rd_sel_q];
    assign rd_last   = rd_avail && ((rd_ptr_q + 1'b1) == rd_len);

    // Next read position, so the output byte is fetched one edge early.
    always @*
    begin
        rd_sel_d = rd_sel_q;
        rd_ptr_d = rd_ptr_q;
        if (rd_release)
        begin
            rd_sel_d = ~rd_sel_q;
            rd_ptr_d = {PW{1'b0}};
        end
        else if (rd_rewind)
            rd_ptr_d = {PW{1'b0}};
        else if (rd_en)
            rd_ptr_d = rd_ptr_q + 1'b1;
    end

    // Buffer storage; not reset, its contents only matter once written.
    always @(posedge clk_sys)
    begin
        if (wr_ok)
            mem[{wr_sel_q, wr_ptr_q[PW-2:0]}] <= wr_data;
        rd_data_q <= mem[{rd_sel_d, rd_ptr_d[PW-2:0]}];
    end

    // Full flags, lengths and pointers.
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            full_q   <= 2'h0;
            len0_q   <= {PW{1'b0}};
            len1_q   <= {PW{1'b0}};
            wr_sel_q <= 1'b0;
            wr_ptr_q <= {PW{1'b0}};
            rd_sel_q <= 1'b0;
            rd_ptr_q <= {PW{1'b0}};
        end
        else
        begin
            rd_sel_q <= rd_sel_d;
            rd_ptr_q <= rd_ptr_d;
            if (rd_release)
                full_q[rd_sel_q] <= 1'b0;
            if (wr_commit)
            begin
                full_q[wr_sel_q] <= 1'b1;
                if (wr_sel_q)
                    len1_q <= wr_cnt;
                else
                    len0_q <= wr_cnt;
                wr_sel_q <= ~wr_sel_q;
                wr_ptr_q <= {PW{1'b0}};
            end
            else
                wr_ptr_q <= wr_cnt;
        end
    end
endmodule

/* src/ued_top.v */
// Endpoint buffer and DMA logic of a full-speed USB device controller.
// Assumes a serial engine that decodes tokens and shifts bytes, a local
// processor on the register port and an external DMA controller.
// How it works
// - answer only matching address and enabled endpoint.
// - IN sends full buffer, else NAK.
// - non-iso IN completes on host ACK.
// - iso IN completes right after data.
// - OUT stores into empty buffer, else NAK.
// - non-iso OUT sends ACK and completes on the same edge.
// - iso OUT completes without handshake.
// - buffer becoming empty raises interrupt.
// - IN request while enabled and buffer free.
// - drop request after burst, then restart.
// - full IN buffer drops request, validates.
// - count done or disable ends transfer.
// - OUT request while enabled and buffer full.
// - drained OUT buffer drops request, clears.
// - OUT termination clears buffer, disables handler.
// - shared bit moves handshake to channel one.
// - status read clears endpoint interrupt bit.
// - only endpoints one to fourteen use DMA.
`include "ued_consts.vh"

module ued_top #(
    parameter DEPTH = 64,
    parameter PW    = 7
) (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        tok_valid,
    input  wire        tok_is_in,
    input  wire [6:0]  tok_addr,
    input  wire [3:0]  tok_ep,
    output wire        tx_valid,
    input  wire        tx_ready,
    output wire [7:0]  tx_data,
    output wire        tx_last,
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_end,
    input  wire        host_ack,
    input  wire        host_timeout,
    output reg         hs_valid,
    output reg  [1:0]  hs_code,
    output wire        irq,
    output wire        periph_dma_request,
    input  wire        periph_dma_acknowledge_n,
    output wire        first_channel_dma_request,
    input  wire        first_channel_dma_acknowledge_n,
    input  wire        host_dma_request,
    output wire        host_dma_acknowledge_n,
    input  wire [7:0]  dma_wdata,
    output wire [7:0]  dma_rdata
);
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_TX   = 2'h1;
    localparam [1:0] S_WACK = 2'h2;
    localparam [1:0] S_RX   = 2'h3;

    // ************
    // Register file.
    // ************
    reg [6:0]  dev_addr_q;
    reg [15:0] ep_en_q;
    reg [15:0] ep_in_q;
    reg [15:0] ep_iso_q;
    reg        dma_en_q;
    reg [3:0]  idx_q;
    reg [7:0]  burst_q;
    reg [15:0] count_q;
    reg [15:0] irq_q;
    reg        shared_q;
    reg [1:0]  st_q;
    reg        gap_q;
    reg [7:0]  bcnt_q;
    reg [15:0] ev_set;
    reg [15:0] rd_clr;
    reg [15:0] rdata_d;

    wire [1:0] pp_full;
    wire       pp_wr_free;
    wire       pp_wr_at_end;
    wire       pp_wr_any;
    wire       pp_rd_avail;
    wire       pp_rd_last;
    wire [7:0] pp_rd_data;

    // True when the endpoint number may be steered to the DMA buffer.
    function dma_capable;
        input [3:0] ep;
        begin
            dma_capable = (ep >= `UED_DMA_EP_FIRST) && (ep <= `UED_DMA_EP_LAST);
        end
    endfunction

    wire wr_cfg   = reg_wr && (reg_addr == `UED_A_DMA_CFG);
    wire in_mode  = ep_in_q[idx_q];
    wire iso_mode = ep_iso_q[idx_q];
    wire dma_ep   = dma_capable(idx_q) && ep_en_q[idx_q];

    // ************
    // Token decode for the serial engine.
    // ************
    wire tok_hit = tok_valid && (st_q == S_IDLE)
                && (tok_addr == dev_addr_q) && ep_en_q[tok_ep];
    wire tok_buf = tok_hit && dma_capable(tok_ep) && (tok_ep == idx_q)
                && (ep_in_q[tok_ep] == tok_is_in);
    wire go_tx   = tok_is_in && tok_buf && pp_rd_avail;
    wire go_rx   = !tok_is_in && tok_buf && pp_wr_free;

    wire tx_end   = (st_q == S_TX) && tx_ready && pp_rd_last;
    wire in_done  = (tx_end && iso_mode)
                 || ((st_q == S_WACK) && host_ack);
    wire out_done = (st_q == S_RX) && rx_end;

    // ************
    // DMA handshake.
    // ************
    wire dma_ack_n = shared_q ? first_channel_dma_acknowledge_n
                              : periph_dma_acknowledge_n;
    wire want_in   = in_mode && pp_wr_free;
    wire want_out  = !in_mode && pp_rd_avail;
    wire dreq      = dma_en_q && dma_ep && (count_q != 16'h0000)
                  && (want_in || want_out) && !gap_q;
    wire dma_xfer  = dreq && !dma_ack_n;
    wire cnt_done  = dma_xfer && (count_q == 16'h0001);
    wire sw_off    = wr_cfg && !reg_wdata[`UED_DMA_EN_BIT] && dma_en_q;
    wire dma_term  = cnt_done || sw_off;
    wire burst_end = dma_xfer && ((bcnt_q + 1'b1) == burst_q);

    // Buffer hookup: DMA fills and USB drains for IN, the reverse for OUT.
    wire pp_wr_en  = in_mode ? dma_xfer
                             : ((st_q == S_RX) && rx_valid);
    wire [7:0] pp_wr_data = in_mode ? dma_wdata : rx_data;
    wire in_fill   = in_mode && dma_xfer && pp_wr_at_end;
    wire in_term   = in_mode && dma_term
                  && (pp_wr_any || dma_xfer);
    wire pp_commit = in_mode ? (in_fill || in_term)
                             : (out_done && pp_wr_any);
    wire out_drain = !in_mode && dma_xfer && pp_rd_last;
    wire out_term  = !in_mode && dma_term && pp_rd_avail;
    wire out_empty = out_drain || out_term;
    wire pp_rd_en  = in_mode ? ((st_q == S_TX) && tx_ready) : dma_xfer;
    wire pp_rel    = in_mode ? in_done : out_empty;
    wire pp_rewind = in_mode && (st_q == S_WACK) && host_timeout;

    ued_pingpong #(
        .DEPTH      (DEPTH),
        .PW         (PW)
    ) u_buf (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .wr_en      (pp_wr_en),
        .wr_data    (pp_wr_data),
        .wr_commit  (pp_commit),
        .rd_en      (pp_rd_en),
        .rd_release (pp_rel),
        .rd_rewind  (pp_rewind),
        .full       (pp_full),
        .wr_free    (pp_wr_free),
        .wr_at_end  (pp_wr_at_end),
        .wr_any     (pp_wr_any),
        .rd_avail   (pp_rd_avail),
        .rd_last    (pp_rd_last),
        .rd_data_q  (pp_rd_data)
    );

    assign tx_valid  = (st_q == S_TX);
    assign tx_data   = pp_rd_data;
    assign tx_last   = pp_rd_last;
    assign dma_rdata = pp_rd_data;
    assign irq       = |irq_q;

    // Shared mode hands the first channel to the peripheral side, and
    // the host side then sees its acknowledge held inactive.
    assign periph_dma_request        = shared_q ? 1'b0 : dreq;
    assign first_channel_dma_request = shared_q ? dreq : host_dma_request;
    assign host_dma_acknowledge_n    = shared_q ? 1'b1
                                                : first_channel_dma_acknowledge_n;

    // Interrupt set and clear vectors for the sticky endpoint bits.
    always @*
    begin
        ev_set = 16'h0000;
        rd_clr = 16'h0000;
        if (in_done || out_done || out_empty)
            ev_set[idx_q] = 1'b1;
        if (reg_rd && reg_addr[4] == `UED_A_EP_STAT_HI)
            rd_clr[reg_addr[3:0]] = 1'b1;
    end

    // Read data mux; unmapped offsets read as zero.
    always @*
    begin
        rdata_d = 16'h0000;
        if (reg_addr[4] == `UED_A_EP_STAT_HI)
        begin
            rdata_d[2] = ep_en_q[reg_addr[3:0]];
            rdata_d[3] = ep_in_q[reg_addr[3:0]];
            rdata_d[4] = ep_iso_q[reg_addr[3:0]];
            if (reg_addr[3:0] == idx_q)
            begin
                rdata_d[1:0] = pp_full;
                rdata_d[5]   = dreq;
            end
        end
        else
        begin
            case (reg_addr)
                `UED_A_DEV_ADDR:  rdata_d[6:0] = dev_addr_q;
                `UED_A_EP_ENABLE: rdata_d = ep_en_q;
                `UED_A_EP_DIR_IN: rdata_d = ep_in_q;
                `UED_A_EP_ISO:    rdata_d = ep_iso_q;
                `UED_A_DMA_CFG:
                begin
                    rdata_d[`UED_DMA_EN_BIT] = dma_en_q;
                    rdata_d[`UED_DMA_IDX_MSB:`UED_DMA_IDX_LSB] = idx_q;
                end
                `UED_A_BURST:     rdata_d[7:0] = burst_q;
                `UED_A_COUNT:     rdata_d = count_q;
                `UED_A_IRQ:       rdata_d = irq_q;
                `UED_A_HW_CFG:    rdata_d[`UED_SHARED_BIT] = shared_q;
                default:          rdata_d = 16'h0000;
            endcase
        end
    end

    // ************
    // Register writes, read data and sticky interrupt bits.
    // ************
    // Changing the endpoint index while a buffer holds data leaves that
    // data attached to the new endpoint; software must drain first.
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            dev_addr_q <= `UED_RST_DEV_ADDR;
            ep_en_q    <= `UED_RST_EP_MASK;
            ep_in_q    <= `UED_RST_EP_MASK;
            ep_iso_q   <= `UED_RST_EP_MASK;
            dma_en_q   <= 1'b0;
            idx_q      <= `UED_RST_IDX;
            burst_q    <= `UED_RST_BURST;
            shared_q   <= 1'b0;
            irq_q      <= 16'h0000;
            reg_rdata  <= 16'h0000;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_d : 16'h0000;
            irq_q     <= ev_set | (irq_q & ~rd_clr);
            if (reg_wr && reg_addr == `UED_A_DEV_ADDR)
                dev_addr_q <= reg_wdata[6:0];
            if (reg_wr && reg_addr == `UED_A_EP_ENABLE)
                ep_en_q <= reg_wdata;
            if (reg_wr && reg_addr == `UED_A_EP_DIR_IN)
                ep_in_q <= reg_wdata;
            if (reg_wr && reg_addr == `UED_A_EP_ISO)
                ep_iso_q <= reg_wdata;
            if (reg_wr && reg_addr == `UED_A_BURST)
                burst_q <= reg_wdata[7:0];
            if (reg_wr && reg_addr == `UED_A_HW_CFG)
                shared_q <= reg_wdata[`UED_SHARED_BIT];
            // A software write wins over the automatic disable.
            if (wr_cfg)
            begin
                dma_en_q <= reg_wdata[`UED_DMA_EN_BIT];
                idx_q    <= reg_wdata[`UED_DMA_IDX_MSB:`UED_DMA_IDX_LSB];
            end
            else if (cnt_done && !in_mode)
                dma_en_q <= 1'b0;
        end
    end

    // ************
    // DMA byte counter and burst pacing.
    // ************
    // The gap holds the request low until the acknowledge has gone
    // inactive, so a new burst never starts inside the old bus grant.
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            count_q <= `UED_RST_COUNT;
            bcnt_q  <= 8'h00;
            gap_q   <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `UED_A_COUNT)
                count_q <= reg_wdata;
            else if (dma_xfer)
                count_q <= count_q - 1'b1;
            if (burst_end || in_fill || out_drain || dma_term || wr_cfg)
                bcnt_q <= 8'h00;
            else if (dma_xfer)
                bcnt_q <= bcnt_q + 1'b1;
            if (burst_end || in_fill || out_drain)
                gap_q <= 1'b1;
            else if (dma_ack_n)
                gap_q <= 1'b0;
        end
    end

    // ************
    // Serial engine sequencing and handshakes.
    // ************
    // An IN that times out waiting for ACK rewinds the buffer, so the
    // same packet goes out again at the next IN token.
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_q     <= S_IDLE;
            hs_valid <= 1'b0;
            hs_code  <= `UED_HS_ACK;
        end
        else
        begin
            hs_valid <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    if (go_tx)
                        st_q <= S_TX;
                    else if (go_rx)
                        st_q <= S_RX;
                    else if (tok_hit)
                    begin
                        hs_valid <= 1'b1;
                        hs_code  <= `UED_HS_NAK;
                    end
                end
                S_TX:
                begin
                    if (tx_end)
                        st_q <= iso_mode ? S_IDLE : S_WACK;
                end
                S_WACK:
                begin
                    if (host_ack || host_timeout)
                        st_q <= S_IDLE;
                end
                S_RX:
                begin
                    if (rx_end)
                    begin
                        st_q <= S_IDLE;
                        if (!iso_mode)
                        begin
                            hs_valid <= 1'b1;
                            hs_code  <= `UED_HS_ACK;
                        end
                    end
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* verif/ued_dma_model.sv */
// Behavioural model of the external DMA controller with two channels.
// Assumes channel 0 serves the peripheral request, channel 1 the first channel.
module ued_dma_model (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       slow,
    input  wire logic [1:0] req,
    output logic      [1:0] ack_n,
    output logic      [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic [2:0] wait_q;

    // Outside a grant the data lines change, so a stale byte is never taken.
    assign wdata = (ack_n != 2'b11) ? cnt_q : ~cnt_q;

    // ************
    // Bus grant, acknowledge and byte source.
    // ************
    // A slow grant models a bus that is busy for a few cycles.
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            ack_n  <= 2'b11;
            cnt_q  <= 8'h00;
            wait_q <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!req[i])
                    ack_n[i] <= 1'b1;
                else if (ack_n[i] && (!slow || wait_q == 3'h3))
                    ack_n[i] <= 1'b0;
                if (req[i] && !ack_n[i])
                    cnt_q <= cnt_q + 8'h01;
            end
            wait_q <= (req != 2'b00 && ack_n == 2'b11) ? wait_q + 3'h1 : 3'h0;
        end
    end
endmodule

/* verif/ued_top_assertions.sv */
// Checker for the endpoint buffer and DMA block, bound to its top.
// Assumes one clock and a synchronous active-high reset.
module ued_top_assertions (
    input wire       clk_sys,
    input wire       reset,
    input wire       tok_valid,
    input wire       rx_end,
    input wire       host_ack,
    input wire       hs_valid,
    input wire       irq,
    input wire       tx_valid,
    input wire       tx_ready,
    input wire [7:0] tx_data,
    input wire       tx_last,
    input wire       periph_dma_request,
    input wire       periph_dma_acknowledge_n,
    input wire       first_channel_dma_request,
    input wire       first_channel_dma_acknowledge_n,
    input wire       host_dma_request,
    input wire       host_dma_acknowledge_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // ************
    // Token answers and data phase.
    // ************
    // Last byte of a data phase handed to the serial engine.
    sequence tx_end_s;
        tx_valid && tx_ready && tx_last;
    endsequence
    hs_cause_a: assert property (hs_valid |-> $past(tok_valid) || $past(rx_end))
        else $error("handshake without token or end of data");
    hs_pulse_a: assert property (hs_valid |=> !hs_valid)
        else $error("handshake longer than one cycle");
    tx_start_a: assert property ($rose(tx_valid) |-> $past(tok_valid))
        else $error("data phase without token");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte changed while stalled");
    tx_stop_a: assert property (tx_end_s |=> !tx_valid)
        else $error("data phase ran past last byte");
    in_done_a: assert property (tx_end_s ##[1:20] host_ack |=> irq)
        else $error("no interrupt after host acknowledge");

    // ************
    // DMA handshake and channel routing.
    // ************
    // The request may only come back once the acknowledge was released.
    dreq_gap_a: assert property (!periph_dma_request && !periph_dma_acknowledge_n
        |=> !periph_dma_request)
        else $error("request back before acknowledge released");
    route_req_a: assert property (periph_dma_request
        |-> first_channel_dma_request == host_dma_request)
        else $error("first channel request not passed through");
    route_ack_a: assert property (!host_dma_acknowledge_n
        |-> first_channel_dma_acknowledge_n == 1'b0)
        else $error("host acknowledge not passed through");
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the endpoint buffer and DMA block.
// Assumes the design, the DMA controller model and the checker are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic        tok_valid = 1'b0, tok_is_in = 1'b0, tx_ready = 1'b0, rx_valid = 1'b0;
    logic        rx_end = 1'b0, host_ack = 1'b0, host_timeout = 1'b0, host_dma_request = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [6:0]  tok_addr = 7'h00;
    logic [3:0]  tok_ep = 4'h3;
    logic [7:0]  rx_data = 8'h00;
    logic [7:0]  mv_w[$], mv_r[$];
    logic [1:0]  hs_last;
    wire  [15:0] reg_rdata;
    wire  [7:0]  tx_data, dma_wdata, dma_rdata;
    wire  [1:0]  hs_code;
    wire         tx_valid, tx_last, hs_valid, irq, host_dma_acknowledge_n;
    wire         periph_dma_request, periph_dma_acknowledge_n;
    wire         first_channel_dma_request, first_channel_dma_acknowledge_n;
    int          n_errors = 0, total_checks = 0, n_hs = 0, n0, burst_n = 0, max_burst = 0;

    ued_top #(.DEPTH(64), .PW(7)) DUT (.*);
    ued_dma_model u_dma (
        .clk_sys (clk_sys),
        .reset   (reset),
        .slow    (slow),
        .req     ({first_channel_dma_request, periph_dma_request}),
        .ack_n   ({first_channel_dma_acknowledge_n, periph_dma_acknowledge_n}),
        .wdata   (dma_wdata)
    );

    // ************
    // Clock, watchdog and monitors.
    // ************
    initial
        forever #5 clk_sys = ~clk_sys;
    // The whole run needs well under a tenth of this span.
    initial
    begin
        #200us;
        n_errors++;
        close_out();
    end
    // Handshakes and DMA moves on the peripheral channel are logged where they happen.
    always @(posedge clk_sys)
    begin
        if (hs_valid)
        begin
            n_hs++;
            hs_last = hs_code;
        end
        if (periph_dma_request && !periph_dma_acknowledge_n)
        begin
            mv_w.push_back(dma_wdata);
            mv_r.push_back(dma_rdata);
            burst_n++;
        end
        else if (!periph_dma_request)
            burst_n = 0;
        if (burst_n > max_burst)
            max_burst = burst_n;
    end

    // ************
    // Access tasks.
    // ************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        @(posedge clk_sys);
    endtask
    task automatic tok(input logic is_in, input logic [6:0] a);
        tok_valid <= 1'b1;
        tok_is_in <= is_in;
        tok_addr <= a;
        @(posedge clk_sys);
        tok_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic pkt(input logic [7:0] b);
        for (int j = 0; j < 3; j++)
        begin
            rx_valid <= 1'b1;
            rx_data <= b + 8'(j);
            @(posedge clk_sys);
        end
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        @(posedge clk_sys);
        rx_end <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic wait_mv(input int n);
        for (int k = 0; k < 500 && mv_r.size() < n; k++)
            @(posedge clk_sys);
    endtask

    // ************
    // Test sequence.
    // ************
    initial
    begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(5'h05, 16'h0010);
        rd(5'h04, 16'h0010);
        wr(5'h09, 16'hffff);
        rd(5'h09, 16'h0000);
        host_dma_request <= 1'b1;
        repeat (4) @(posedge clk_sys);
        host_dma_request <= 1'b0;
        wr(5'h00, 16'h0005);
        wr(5'h01, 16'h0008);
        wr(5'h02, 16'h0008);
        wr(5'h05, 16'h0004);
        wr(5'h06, 16'h0006);
        slow <= 1'b1;
        wr(5'h04, 16'h0031);
        wait_mv(6);
        rd(5'h06, 16'h0000);
        chk(16'(max_burst), 16'h0004);
        rd(5'h13, 16'h000d);
        n0 = n_hs;
        tok(1'b1, 7'h06);
        tok_ep <= 4'h4;
        tok(1'b1, 7'h05);
        tok_ep <= 4'h3;
        chk(16'(n_hs - n0), 16'h0000);
        // First pass times out and must resend the same packet.
        for (int r = 0; r < 2; r++)
        begin
            tok(1'b1, 7'h05);
            for (int i = 0; i < 6; i++)
            begin
                tx_ready <= 1'b1;
                #1;
                chk(tx_data, mv_w[i]);
                chk(tx_last, i == 5);
                @(posedge clk_sys);
                tx_ready <= 1'b0;
                @(posedge clk_sys);
            end
            chk(irq, 1'b0);
            host_ack <= r[0];
            host_timeout <= !r[0];
            @(posedge clk_sys);
            host_ack <= 1'b0;
            host_timeout <= 1'b0;
            @(posedge clk_sys);
        end
        rd(5'h07, 16'h0008);
        rd(5'h13, 16'h000c);
        chk(irq, 1'b0);
        n0 = n_hs;
        tok(1'b1, 7'h05);
        chk(16'(n_hs - n0), 16'h0001);
        chk(hs_last, 2'h1);
        wr(5'h02, 16'h0000);
        for (int k = 0; k < 3; k++)
        begin
            n0 = n_hs;
            tok(1'b0, 7'h05);
            if (k < 2)
                pkt(8'ha0 + 8'(16 * k));
            chk(16'(n_hs - n0), 16'h0001);
            chk(hs_last, (k < 2) ? 2'h0 : 2'h1);
        end
        rd(5'h13, 16'h0007);
        mv_r.delete();
        slow <= 1'b0;
        wr(5'h05, 16'h0010);
        wr(5'h06, 16'h0004);
        wr(5'h04, 16'h0031);
        wait_mv(4);
        for (int j = 0; j < 4; j++)
            chk(mv_r[j], (j < 3) ? 8'ha0 + 8'(j) : 8'hb0);
        repeat (4) @(posedge clk_sys);
        rd(5'h07, 16'h0008);
        rd(5'h13, 16'h0004);
        rd(5'h04, 16'h0030);
        wr(5'h03, 16'h0008);
        wr(5'h08, 16'h0001);
        n0 = n_hs;
        tok(1'b0, 7'h05);
        pkt(8'hc0);
        chk(16'(n_hs - n0), 16'h0000);
        chk(irq, 1'b1);
        wr(5'h06, 16'h0003);
        wr(5'h04, 16'h0031);
        repeat (20) @(posedge clk_sys);
        chk(16'(mv_r.size()), 16'h0004);
        rd(5'h06, 16'h0000);
        close_out();
    end
endmodule

bind ued_top ued_top_assertions u_chk (.*);
